// ---- inc/bbc_pkg.sv ----
// constants and types shared by the instruction execution block
package bbc_pkg;
  localparam int          CLK_NS         = 10;
  localparam int          INSTR_CYCLE_NS = 40;
  localparam int          CLKS_PER_INSTR = INSTR_CYCLE_NS / CLK_NS;
  localparam int          PC_W           = 21;
  localparam int          DADDR_W        = 12;
  localparam int          STATUS_W       = 5;
  localparam int          ST_Z           = 2;
  localparam int          ST_OV          = 3;
  localparam logic [4:0]  STATUS_RST     = 5'h00;
  localparam logic [20:0] PC_RST         = 21'h000000;
  localparam logic [20:0] PC_STEP        = 21'h000002;
  localparam logic [15:0] OP_NOP         = 16'h0000;
  localparam logic [3:0]  OP_BIT_INVERT  = 4'h7;
  localparam logic [6:0]  OP_REG_ZERO    = 7'h35;
  localparam logic [7:0]  OP_BR_OVF      = 8'he4;
  localparam logic [7:0]  OP_BR_ZERO     = 8'he0;
  localparam logic [6:0]  OP_CALL        = 7'h76;
  localparam logic [7:0]  INDEXED_MAX    = 8'h5f;
  localparam logic [3:0]  ACCESS_LO_BANK = 4'h0;
  localparam logic [3:0]  ACCESS_HI_BANK = 4'hf;
  localparam logic [7:0]  ZERO_BYTE      = 8'h00;

  typedef enum logic [1:0] {
    Q1 = 2'b00,
    Q2 = 2'b01,
    Q3 = 2'b11,
    Q4 = 2'b10
  } bbc_phase_t;
endpackage

// ---- hw/bbc_qphase.sv ----
// four-phase divider of the instruction cycle
`timescale 1ns/1ps
module bbc_qphase import bbc_pkg::*; (
  input  wire logic       clk,
  input  wire logic       rst_n,
  output bbc_phase_t      phase
);
  typedef struct packed {
    bbc_phase_t phase;
  } bbc_qstate_t;

  bbc_qstate_t st;
  bbc_qstate_t next_st;

  always_comb begin
    next_st = st;
    case (st.phase)
      Q1: next_st.phase = Q2;
      Q2: next_st.phase = Q3;
      Q3: next_st.phase = Q4;
      Q4: next_st.phase = Q1;
      default: next_st.phase = Q1;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{phase: Q1};
    end else begin
      st <= next_st;
    end
  end

  assign phase = st.phase;

  a_phase_ring: assert property (@(posedge clk) disable iff (!rst_n)
    (st.phase == Q4) |=> (st.phase == Q1)) else $error("phase ring broken");
endmodule // bbc_qphase

// ---- hw/bbc_core.sv ----
// execution of bit invert, flag branches, two-word call and register clear
// Operation
// - bit invert flips one bit, flags kept
// - bank flag picks access bank or bank register
// - extended set, offsets up to 95 indexed
// - branch on overflow only when overflow set
// - branch on zero only when zero set
// - taken target is branch address plus 2+2n
// - branch one cycle, taken two with flush
// - call pushes call address plus four first
// - shadow flag copies accumulator, flags, bank
// - call target twenty bits into pc 20:1
// - register clear writes zero, sets zero flag
`timescale 1ns/1ps
module bbc_core import bbc_pkg::*; (
  input  wire logic                CLK,
  input  wire logic                RSTN,
  input  wire logic [15:0]         PROG_DATA,
  input  wire logic [7:0]          DATA_RDATA,
  input  wire logic [3:0]          BANK_SEL,
  input  wire logic [7:0]          ACCUMULATOR,
  input  wire logic [DADDR_W-1:0]  INDEX_BASE,
  input  wire logic                EXT_SET_EN,
  input  wire logic                STATUS_WR,
  input  wire logic [STATUS_W-1:0] STATUS_WDATA,
  output logic [PC_W-1:0]          PROG_ADDR,
  output logic [DADDR_W-1:0]       DATA_ADDR,
  output logic                     DATA_RE,
  output logic                     DATA_WE,
  output logic [7:0]               DATA_WDATA,
  output logic [STATUS_W-1:0]      STATUS,
  output logic                     STACK_PUSH,
  output logic [PC_W-1:0]          STACK_TOP,
  output logic [7:0]               ACCUMULATOR_SHADOW,
  output logic [STATUS_W-1:0]      FLAGS_SHADOW,
  output logic [3:0]               BANK_SELECT_SHADOW,
  output bbc_phase_t               INSTR_PHASE
);
  typedef struct packed {
    logic [PC_W-1:0]     pc;
    logic [15:0]         ir;
    logic [7:0]          rdata;
    logic [DADDR_W-1:0]  daddr;
    logic [7:0]          wdata;
    logic                re;
    logic                we;
    logic [STATUS_W-1:0] status;
    logic                push;
    logic [PC_W-1:0]     stack_top;
    logic [7:0]          acc_sh;
    logic [STATUS_W-1:0] flags_sh;
    logic [3:0]          bank_sh;
  } bbc_core_t;

  localparam bbc_core_t CORE_RST = '{
    pc: PC_RST, ir: OP_NOP, rdata: ZERO_BYTE, daddr: '0, wdata: ZERO_BYTE,
    re: 1'b0, we: 1'b0, status: STATUS_RST, push: 1'b0, stack_top: PC_RST,
    acc_sh: ZERO_BYTE, flags_sh: STATUS_RST, bank_sh: ACCESS_LO_BANK
  };

  logic [1:0]          rst_sync;
  logic                rst_n;
  bbc_phase_t          phase;
  bbc_core_t           st;
  bbc_core_t           next_st;
  logic                is_bit_inv;
  logic                is_reg_zero;
  logic                is_br_ovf;
  logic                is_br_zero;
  logic                is_call;
  logic                is_file;
  logic                br_taken;
  logic [7:0]          bit_mask;
  logic [7:0]          fld;
  logic [PC_W-1:0]     br_offset;
  logic [DADDR_W-1:0]  eff_addr;

  // release of the async reset is retimed so every flop leaves reset together
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  bbc_qphase u_qphase (
    .clk   (CLK),
    .rst_n (rst_n),
    .phase (phase)
  );

  assign fld         = st.ir[7:0];
  assign is_bit_inv  = (st.ir[15:12] == OP_BIT_INVERT);
  assign is_reg_zero = (st.ir[15:9] == OP_REG_ZERO);
  assign is_br_ovf   = (st.ir[15:8] == OP_BR_OVF);
  assign is_br_zero  = (st.ir[15:8] == OP_BR_ZERO);
  assign is_call     = (st.ir[15:9] == OP_CALL);
  assign is_file     = is_bit_inv | is_reg_zero;
  assign bit_mask    = 8'h01 << st.ir[11:9];
  // flags come from the register, so a branch never touches them
  assign br_taken    = (is_br_ovf & st.status[ST_OV])
                     | (is_br_zero & st.status[ST_Z]);
  // pc already points past the branch, so adding 2n lands on branch+2+2n
  assign br_offset   = {{12{fld[7]}}, fld, 1'b0};

  always_comb begin
    if (st.ir[8]) begin
      eff_addr = {BANK_SEL, fld};
    end else if (EXT_SET_EN && (fld <= INDEXED_MAX)) begin
      eff_addr = INDEX_BASE + {4'h0, fld};
    end else if (fld <= INDEXED_MAX) begin
      eff_addr = {ACCESS_LO_BANK, fld};
    end else begin
      eff_addr = {ACCESS_HI_BANK, fld};
    end
  end

  always_comb begin
    next_st      = st;
    next_st.push = 1'b0;
    case (phase)
      Q1: begin
        next_st.daddr = eff_addr;
        next_st.re    = is_file;
      end
      Q2: begin
        next_st.re    = 1'b0;
        next_st.rdata = DATA_RDATA;
      end
      Q3: begin
        if (is_bit_inv) begin
          next_st.wdata = st.rdata ^ bit_mask;
          next_st.we    = 1'b1;
        end else if (is_reg_zero) begin
          next_st.wdata = ZERO_BYTE;
          next_st.we    = 1'b1;
        end
        if (is_call) begin
          next_st.push = 1'b1;
          next_st.stack_top  = st.pc + PC_STEP;
          if (st.ir[8]) begin
            next_st.acc_sh   = ACCUMULATOR;
            next_st.flags_sh = st.status;
            next_st.bank_sh  = BANK_SEL;
          end
        end
      end
      Q4: begin
        next_st.we = 1'b0;
        if (STATUS_WR) begin
          next_st.status = STATUS_WDATA;
        end
        // the clear sets zero last so it wins over an outside flag write
        if (is_reg_zero) begin
          next_st.status[ST_Z] = 1'b1;
        end
        if (br_taken) begin
          next_st.pc = st.pc + br_offset;
          next_st.ir = OP_NOP;
        end else if (is_call) begin
          // second word arrives on the fetch bus in this very phase
          next_st.pc = {PROG_DATA[11:0], fld, 1'b0};
          next_st.ir = OP_NOP;
        end else begin
          next_st.ir = PROG_DATA;
          next_st.pc = st.pc + PC_STEP;
        end
      end
      default: next_st = st;
    endcase
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      st <= CORE_RST;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      INSTR_PHASE <= Q1;
    end else begin
      INSTR_PHASE <= phase;
    end
  end

  assign PROG_ADDR          = st.pc;
  assign DATA_ADDR          = st.daddr;
  assign DATA_RE            = st.re;
  assign DATA_WE            = st.we;
  assign DATA_WDATA         = st.wdata;
  assign STATUS             = st.status;
  assign STACK_PUSH         = st.push;
  assign STACK_TOP          = st.stack_top;
  assign ACCUMULATOR_SHADOW = st.acc_sh;
  assign FLAGS_SHADOW       = st.flags_sh;
  assign BANK_SELECT_SHADOW = st.bank_sh;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n);

  sequence s_decode;  phase == Q1 && is_file; endsequence
  sequence s_read;    DATA_RE && !DATA_WE; endsequence
  sequence s_write;   DATA_WE && !DATA_RE; endsequence

  a_file_phases: assert property (s_decode |=> s_read ##2 s_write)
    else $error("file op phase order wrong");
  a_invert_data: assert property ((phase == Q3 && is_bit_inv) |=>
    (DATA_WDATA == ($past(st.rdata) ^ $past(bit_mask)))) else $error("bit invert wrong");
  a_invert_flags: assert property ((phase == Q4 && is_bit_inv && !STATUS_WR) |=>
    $stable(STATUS)) else $error("bit invert touched flags");
  a_bank_addr: assert property ((phase == Q1 && is_file && st.ir[8]) |=>
    (DATA_ADDR == {$past(BANK_SEL), $past(fld)})) else $error("bank address wrong");
  a_indexed_addr: assert property ((phase == Q1 && is_file && !st.ir[8] && EXT_SET_EN
    && fld <= INDEXED_MAX) |=> (DATA_ADDR == $past(INDEX_BASE) + {4'h0, $past(fld)}))
    else $error("indexed address wrong");
  a_branch_target: assert property ((phase == Q4 && br_taken) |=>
    (PROG_ADDR == $past(st.pc) + $past(br_offset)) && st.ir == OP_NOP) else $error("branch bad");
  a_branch_hold: assert property ((phase == Q4 && (is_br_ovf || is_br_zero) && !br_taken)
    |=> (PROG_ADDR == $past(st.pc) + PC_STEP)) else $error("untaken branch moved pc");
  a_call_push: assert property ((phase == Q3 && is_call) |=>
    STACK_PUSH && (STACK_TOP == $past(st.pc) + PC_STEP) ##1 !STACK_PUSH)
    else $error("call push wrong");
  a_shadow_keep: assert property ((phase == Q3 && is_call && !st.ir[8]) |=>
    $stable(ACCUMULATOR_SHADOW) && $stable(FLAGS_SHADOW) && $stable(BANK_SELECT_SHADOW))
    else $error("shadow changed without flag");
  a_call_target: assert property ((phase == Q4 && is_call) |=>
    (PROG_ADDR == {$past(PROG_DATA[11:0]), $past(fld), 1'b0}) && st.ir == OP_NOP
    ##4 (PROG_ADDR == $past(PROG_ADDR, 4) + PC_STEP)) else $error("call target wrong");
  a_clear_zero: assert property ((phase == Q4 && is_reg_zero) |=>
    STATUS[ST_Z] && $past(DATA_WE) && $past(DATA_WDATA) == ZERO_BYTE)
    else $error("register clear wrong");
endmodule // bbc_core

// ---- bench/bbc_core_tb_top.sv ----
// self-checking bench for the execution block, with a model built from queues
`timescale 1ns/1ps
module bbc_core_tb_top import bbc_pkg::*; ;
  logic        clk  = 1'b0;
  logic        rstn = 1'b0;
  logic        ext  = 1'b0;
  logic        swr  = 1'b0;
  logic [15:0] pdat = 16'h0000;
  logic [7:0]  rdat = 8'h00;
  logic [7:0]  acc  = 8'h00;
  logic [3:0]  bsel = 4'h0;
  logic [11:0] ibase = 12'h000;
  logic [4:0]  swd  = 5'h00;
  logic [20:0] pa, stop;
  logic [11:0] da;
  logic        re, we, push;
  logic [7:0]  wd, ash;
  logic [4:0]  st, fsh;
  logic [3:0]  bsh;
  logic [1:0]  iph;
  logic [7:0]  dmem [4096];
  logic [15:0] prog [int];
  logic [4:0]  mark [int];
  int          n_errors = 0;
  int          samples_checked = 0;
  int          q_pc[$], q_st[$], q_wr[$], q_push[$];
  int          pc, mst, msh, last_pa, cnt, since_re, seen;
  int          md [4096];

  always #5 clk = ~clk;

  bbc_core u_dut (.CLK(clk), .RSTN(rstn), .PROG_DATA(pdat), .DATA_RDATA(rdat),
    .BANK_SEL(bsel), .ACCUMULATOR(acc), .INDEX_BASE(ibase), .EXT_SET_EN(ext),
    .STATUS_WR(swr), .STATUS_WDATA(swd), .PROG_ADDR(pa), .DATA_ADDR(da), .DATA_RE(re),
    .DATA_WE(we), .DATA_WDATA(wd), .STATUS(st), .STACK_PUSH(push), .STACK_TOP(stop),
    .ACCUMULATOR_SHADOW(ash), .FLAGS_SHADOW(fsh), .BANK_SELECT_SHADOW(bsh),
    .INSTR_PHASE(iph));

  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // program and data memories answer just after each edge; flag writes ride on pc
  always @(posedge clk) begin
    #1;
    pdat = prog.exists(int'(pa)) ? prog[int'(pa)] : 16'h0000;
    rdat = dmem[da];
    swr = mark.exists(int'(pa));
    swd = swr ? mark[int'(pa)] : 5'($urandom);
    since_re = re ? 0 : since_re + 1;
    if (rstn && pa !== last_pa[20:0]) begin
      if (seen) check("pc spacing", cnt, 4);
      check("phase lag", iph, 2'h2);
      check("prog addr", pa, q_pc.pop_front());
      check("status", st, q_st.pop_front());
      last_pa = pa;
      cnt = 0;
      seen = 1;
    end
    cnt++;
    if (we) begin
      check("write", {da, wd}, q_wr.pop_front());
      check("read lead", since_re, 2);
      dmem[da] = wd;
    end
    if (push) begin
      check("stack top", stop, q_push.pop_front());
      check("shadows", {ash, fsh, bsh}, q_push.pop_front());
    end
  end

  // a fetch of this word moves pc on and shows flags left by the one before
  task automatic emit(input logic [15:0] w);
    if (mark.exists(pc)) mst = mark[pc];
    prog[pc] = w;
    q_pc.push_back(pc + 2);
    q_st.push_back(mst);
  endtask

  // program hops back only into unused gaps, so the model never revisits a word
  task automatic build();
    int a, f, b, k, ad, op, n, hop;
    pc = 0;
    hop = 0;
    for (int i = 0; i < 48; i++) begin
      op = hop ? 4 : $urandom_range(0, 6);
      hop = 0;
      a = $urandom_range(0, 1);
      f = $urandom_range(0, 255);
      b = $urandom_range(0, 7);
      ad = a ? {bsel, f[7:0]} : (f <= 95 && ext) ? (ibase + f) & 'hfff : f <= 95 ? f : 'hf00 + f;
      case (op)
        0, 1: begin
          emit(op ? {7'h35, a[0], f[7:0]} : {4'h7, b[2:0], a[0], f[7:0]});
          md[ad] = op ? 0 : md[ad] ^ (1 << b);
          q_wr.push_back(ad * 256 + md[ad]);
          if (op) mst = mst | 4;
          pc += 2;
        end
        2, 3: begin
          // a zero hop leaves pc where it is and would hide the redirect
          if (f[6:0] == 0) f = 1;
          emit({(op == 2) ? 8'he4 : 8'he0, 1'b0, f[6:0]});
          if (mst[(op == 2) ? 3 : 2]) begin
            pc = pc + 2 + 2 * f[6:0];
            q_pc.push_back(pc);
            q_st.push_back(mst);
          end else pc += 2;
        end
        4: begin
          // wide unused gap below each target leaves room for a backward hop
          k = pc / 2 + 260 + $urandom_range(0, 4000);
          emit({7'h76, a[0], k[7:0]});
          prog[pc + 2] = {4'($urandom), k[19:8]};
          q_push.push_back(pc + 4);
          if (a) msh = {acc, mst[4:0], bsel};
          q_push.push_back(msh);
          pc = k * 2;
          q_pc.push_back(pc);
          q_st.push_back(mst);
          if (mst[2]) begin
            // negative offset lands in the gap; a forced call climbs out again
            n = -$urandom_range(3, 128);
            emit({8'he0, 8'(n)});
            pc = pc + 2 + 2 * n;
            q_pc.push_back(pc);
            q_st.push_back(mst);
            hop = 1;
          end
        end
        6: begin
          // clear and outside flag write share one write phase: zero still ends set
          emit({7'h35, a[0], f[7:0]});
          md[ad] = 0;
          q_wr.push_back(ad * 256);
          pc += 2;
          mark[pc] = 5'($urandom);
          emit(16'h0000);
          mst = mst | 4;
          q_st[$] = mst;
          pc += 2;
        end
        default: begin
          // leading nop keeps a clear from merging into the flag write
          emit(16'h0000);
          pc += 2;
          mark[pc] = 5'($urandom);
          emit(16'h0000);
          pc += 2;
        end
      endcase
    end
    for (int i = 0; i < 2; i++) begin
      emit(16'h0000);
      pc += 2;
    end
  endtask

  initial begin
    void'($urandom(24782));
    for (int run = 0; run < 2; run++) begin
      @(posedge clk);
      #1;
      rstn = 1'b0;
      ext = run[0];
      acc = 8'($urandom);
      bsel = 4'($urandom);
      ibase = 12'($urandom);
      prog.delete();
      mark.delete();
      mst = 0;
      msh = 0;
      last_pa = 0;
      seen = 0;
      for (int i = 0; i < 4096; i++) begin
        dmem[i] = 8'($urandom);
        md[i] = dmem[i];
      end
      build();
      repeat (16) @(posedge clk);
      #1;
      rstn = 1'b1;
      for (int i = 0; i < 3000 && q_pc.size() > 0; i++) @(posedge clk);
      #2;
      check("leftover", q_pc.size() + q_wr.size() + q_push.size(), 0);
      rstn = 1'b0;
      $display("run %0d done", run);
    end
    complete_run();
  end

  // two short runs need well under this many cycles
  initial begin
    #100000;
    n_errors++;
    complete_run();
  end
endmodule // bbc_core_tb_top
